//--- logic/ser_pkg.sv
package ser_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SER_W = 8;

  // ----------------------------------------
  // Event status bit positions
  // ----------------------------------------
  localparam int SER_EV_POWER_UP = 7;
  localparam int SER_EV_USER_REQ = 6;
  localparam int SER_EV_CMD_ERR = 5;
  localparam int SER_EV_ACT_FAIL = 4;
  localparam int SER_EV_DEV_ERR = 3;
  localparam int SER_EV_QRY_ERR = 2;
  localparam int SER_EV_CTL_REQ = 1;
  localparam int SER_EV_OP_DONE = 0;

  // ----------------------------------------
  // Error flag bit positions
  // ----------------------------------------
  localparam int SER_ER_SPARE = 7;
  localparam int SER_ER_LEN = 6;
  localparam int SER_ER_HDR = 5;
  localparam int SER_ER_FMT = 4;
  localparam int SER_ER_RNG = 3;
  localparam int SER_ER_UNX = 2;
  localparam int SER_ER_LNK = 1;
  localparam int SER_ER_BKP = 0;

  // ----------------------------------------
  // Status byte positions
  // ----------------------------------------
  localparam int SER_STB_EVENT_SUM = 5;
  localparam int SER_STB_MASTER = 6;

  // ----------------------------------------
  // Reset values and masks of implemented bits
  // ----------------------------------------
  localparam logic [SER_W-1:0] SER_ZERO = 8'h00;
  localparam logic [SER_W-1:0] SER_EV_USED = 8'hBD;
  localparam logic [SER_W-1:0] SER_ER_USED = 8'h7F;
  localparam logic SER_POWER_UP_RST = 1'b1;

  typedef enum logic [1:0] {
    SER_DONE_IDLE = 2'b01,
    SER_DONE_WAIT = 2'b10
  } ser_done_state_t;

endpackage : ser_pkg

//--- logic/ser_status_event.sv
// Function
// - Event summary bit is set when any enabled event status bit is set.
// - Event status clears at power-up, clear-status and error readout query.
// - Power-on flag, top bit, set at power-up or after supply outage recovery.
// - Command errors set command flag; input ignored until next terminator.
// - Out-of-range, unappliable or blocked commands set execution error flag.
// - Other failures such as internal anomalies set device-dependent flag.
// - Queue overflow, loss or GP-IB empty read set query flag, flush queue.
// - Operation-complete bit set only after all earlier messages finished.
// - Eight-bit enable mask selects which event bits feed the summary.
// - Error register feeds command, execution, device and query bits unmasked.
// - Clear-status clears event status, error register and the operation-complete wait together.
// - Overlong message sets error bit 6; all error bits clear on read.
// - Unrecognised header sets error bit 5.
// - Too many or unrecognised parameters set error bit 4.
// - Parameter outside range sets error bit 3.
// - Unexecutable command sets error bit 2.
// - Internal link fault sets error bit 1, corrupt backup memory bit 0.
// - Enabled status byte bit sets master summary bit 6 and service request.
`timescale 1ns/100ps

module ser_status_event #(
  parameter int WIDTH = ser_pkg::SER_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Commands from the parser
  input wire logic clear_status,
  input wire logic error_query,
  input wire logic complete_cmd,
  input wire logic enable_write,
  input wire logic [WIDTH-1:0] enable_wdata,
  input wire logic terminator_seen,
  input wire logic ops_busy,
  input wire logic power_restored,
  // Parse and execution faults, one-cycle pulses
  input wire logic cmd_syntax_error,
  input wire logic exec_error,
  input wire logic device_error,
  input wire logic overlong_message,
  input wire logic header_fault,
  input wire logic format_fault,
  input wire logic range_fault,
  input wire logic unexecutable_cmd,
  input wire logic internal_link_fault,
  input wire logic backup_corrupt,
  // Output queue conditions
  input wire logic queue_overflow,
  input wire logic queue_data_lost,
  input wire logic empty_queue_read,
  input wire logic link_is_gpib,
  // Status byte link
  input wire logic [WIDTH-1:0] status_byte_in,
  input wire logic [WIDTH-1:0] srq_enable,
  // Register views
  output logic [WIDTH-1:0] event_status,
  output logic [WIDTH-1:0] event_status_enable,
  output logic [WIDTH-1:0] error_read_data,
  // Summary and side effects
  output logic event_summary_bit,
  output logic master_summary,
  output logic service_request,
  output logic flush_output_queue,
  output logic skip_to_terminator
);
  import ser_pkg::*;

  if (WIDTH != SER_W) begin : g_width_check
    $error("ser_status_event: WIDTH must be 8");
  end

  function automatic logic any_enabled(input logic [SER_W-1:0] bits, input logic [SER_W-1:0] mask);
    any_enabled = |(bits & mask);
  endfunction : any_enabled

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic [SER_W-1:0] ev_reg, ev_next, ev_set;
  logic [SER_W-1:0] er_reg, er_next, er_set;
  logic [SER_W-1:0] mask_reg, mask_next;
  logic [SER_W-1:0] rd_reg, rd_next;
  logic boot_reg, boot_next;
  logic wipe;
  logic cmd_err;
  logic qry_err;
  logic done_pulse;

  assign cmd_err = cmd_syntax_error | header_fault | format_fault;
  // queue faults, empty read counts on GP-IB only
  assign qry_err = queue_overflow | queue_data_lost | (empty_queue_read & link_is_gpib);
  assign wipe = clear_status | error_query;

  always_comb begin
    er_set = SER_ZERO;
    er_set[SER_ER_LEN] = overlong_message;
    er_set[SER_ER_HDR] = header_fault;
    er_set[SER_ER_FMT] = format_fault;
    er_set[SER_ER_RNG] = range_fault;
    er_set[SER_ER_UNX] = unexecutable_cmd;
    er_set[SER_ER_LNK] = internal_link_fault;
    er_set[SER_ER_BKP] = backup_corrupt;
  end

  always_comb begin
    ev_set = SER_ZERO;
    ev_set[SER_EV_POWER_UP] = boot_reg | power_restored;
    ev_set[SER_EV_CMD_ERR] = cmd_err | er_set[SER_ER_HDR] | er_set[SER_ER_FMT];
    ev_set[SER_EV_ACT_FAIL] = exec_error | er_set[SER_ER_RNG] | er_set[SER_ER_UNX];
    ev_set[SER_EV_DEV_ERR] = device_error | er_set[SER_ER_LNK] | er_set[SER_ER_BKP];
    ev_set[SER_EV_QRY_ERR] = qry_err | er_set[SER_ER_LEN];
    ev_set[SER_EV_OP_DONE] = done_pulse;
  end

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  always_comb begin
    // new events beat a clear in the same cycle
    ev_next = ((wipe ? SER_ZERO : ev_reg) | ev_set) & SER_EV_USED;
    // read or clear-status empties errors, set still wins
    er_next = ((wipe ? SER_ZERO : er_reg) | er_set) & SER_ER_USED;
    mask_next = enable_write ? enable_wdata : mask_reg;
    // Read data holds the value seen by the query
    rd_next = error_query ? er_reg : rd_reg;
    boot_next = 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_reg <= SER_ZERO;
      er_reg <= SER_ZERO;
      mask_reg <= SER_ZERO;
      rd_reg <= SER_ZERO;
      boot_reg <= SER_POWER_UP_RST;
    end else begin
      ev_reg <= ev_next;
      er_reg <= er_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      boot_reg <= boot_next;
    end
  end

  // ----------------------------------------
  // Operation-complete wait
  // ----------------------------------------
  ser_done_state_t done_reg, done_next;

  always_comb begin
    done_next = done_reg;
    done_pulse = 1'b0;
    unique case (done_reg)
      SER_DONE_IDLE: begin
        if (complete_cmd) begin
          done_next = SER_DONE_WAIT;
        end
      end
      SER_DONE_WAIT: begin
        if (clear_status) begin
          done_next = SER_DONE_IDLE;
        end else if (!ops_busy) begin
          done_pulse = 1'b1;
          done_next = SER_DONE_IDLE;
        end
      end
      // Upset codes drop the wait rather than lock it up
      default: begin
        done_next = SER_DONE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= SER_DONE_IDLE;
    end else begin
      done_reg <= done_next;
    end
  end

  // ----------------------------------------
  // Summaries and side effects
  // ----------------------------------------
  logic sum_reg, sum_next;
  logic master_reg, master_next;
  logic srq_reg, srq_next;
  logic flush_reg, flush_next;
  logic skip_reg, skip_next;
  logic [SER_W-1:0] stb_view;

  always_comb begin
    // summary built from the next event bits and mask, in step with the registers
    sum_next = any_enabled(ev_next, mask_next);
    // Master bit excluded from its own sum to avoid a loop
    stb_view = status_byte_in;
    stb_view[SER_STB_EVENT_SUM] = sum_next;
    stb_view[SER_STB_MASTER] = 1'b0;
    // master summary and request on a rise
    master_next = any_enabled(stb_view, srq_enable);
    srq_next = master_next & ~master_reg;
    flush_next = qry_err;
    // skip to terminator, a new error wins
    skip_next = cmd_err | (skip_reg & ~terminator_seen);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sum_reg <= 1'b0;
      master_reg <= 1'b0;
      srq_reg <= 1'b0;
      flush_reg <= 1'b0;
      skip_reg <= 1'b0;
    end else begin
      sum_reg <= sum_next;
      master_reg <= master_next;
      srq_reg <= srq_next;
      flush_reg <= flush_next;
      skip_reg <= skip_next;
    end
  end

  assign event_status = ev_reg;
  assign event_status_enable = mask_reg;
  assign error_read_data = rd_reg;
  assign event_summary_bit = sum_reg;
  assign master_summary = master_reg;
  assign service_request = srq_reg;
  assign flush_output_queue = flush_reg;
  assign skip_to_terminator = skip_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_summary_mask: assert property (
    event_summary_bit == |(event_status & event_status_enable))
    else $error("summary bit disagrees with masked events");

  chk_clear_wipes_events: assert property (
    (clear_status || error_query) |=> ((event_status & ~$past(ev_set)) == SER_ZERO))
    else $error("events survived a clear");

  chk_power_restore: assert property (
    power_restored |=> event_status[SER_EV_POWER_UP])
    else $error("power-on flag not set");

  chk_cmd_err_skip: assert property (
    cmd_syntax_error |=> (event_status[SER_EV_CMD_ERR] && skip_to_terminator))
    else $error("command error did not set flag and skip");

  chk_skip_until_term: assert property (
    (skip_to_terminator && !terminator_seen) |=> skip_to_terminator)
    else $error("input skipping ended before a terminator");

  chk_skip_release: assert property (
    (skip_to_terminator && terminator_seen && !cmd_err) |=> !skip_to_terminator)
    else $error("input skipping outlived the terminator");

  chk_range_to_action: assert property (
    range_fault |=> (event_status[SER_EV_ACT_FAIL] && er_reg[SER_ER_RNG]))
    else $error("range fault not reported");

  chk_backup_to_device: assert property (
    (backup_corrupt || internal_link_fault) |=> event_status[SER_EV_DEV_ERR])
    else $error("device fault not reported");

  chk_query_flush: assert property (
    (queue_overflow || (empty_queue_read && link_is_gpib)) |=> (event_status[SER_EV_QRY_ERR] && flush_output_queue)
      ##1 !flush_output_queue || $past(qry_err))
    else $error("query error without one flush pulse");

  chk_done_after_busy: assert property (
    $rose(event_status[SER_EV_OP_DONE]) |-> ($past(done_reg) == SER_DONE_WAIT) && !$past(ops_busy))
    else $error("operation complete before work drained");

  chk_enable_write: assert property (
    enable_write |=> (event_status_enable == $past(enable_wdata)))
    else $error("enable mask write not taken");

  chk_overlong_len: assert property (
    overlong_message |=> (er_reg[SER_ER_LEN] && event_status[SER_EV_QRY_ERR]))
    else $error("overlong message not recorded");

  chk_read_holds: assert property (
    !error_query |=> $stable(error_read_data))
    else $error("error read data changed without a query");

  chk_err_read_clear: assert property (
    error_query |=> (error_read_data == $past(er_reg)) && ((er_reg & ~$past(er_set)) == SER_ZERO))
    else $error("error read did not return and clear");

  chk_header_to_cmd: assert property (
    (header_fault || format_fault) |=> (event_status[SER_EV_CMD_ERR] && |er_reg[SER_ER_HDR:SER_ER_FMT]))
    else $error("header or format fault lost");

  chk_unused_zero: assert property (
    !event_status[SER_EV_USER_REQ] && !event_status[SER_EV_CTL_REQ] && !er_reg[SER_ER_SPARE])
    else $error("unused bit set");

  chk_srq_on_rise: assert property (
    service_request |-> (master_summary && !$past(master_summary)))
    else $error("service request without rising summary");

  cov_done_waited: cover property (
    complete_cmd && ops_busy ##1 ops_busy [*4] ##1 !ops_busy ##1 event_status[SER_EV_OP_DONE]);

  cov_err_read_nonzero: cover property (
    error_query && (er_reg != SER_ZERO));

  cov_srq_raised: cover property (
    service_request);

  cov_set_beats_clear: cover property (
    clear_status && header_fault ##1 event_status[SER_EV_CMD_ERR]);

  cov_serial_empty_read: cover property (
    empty_queue_read && !link_is_gpib);

endmodule : ser_status_event

//--- dv/ser_ctrl_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Remote controller issuing decoded status commands
// ----------------------------------------
module ser_ctrl_model (
  // Clock
  input wire logic clk,
  // Commands towards the block
  output logic clear_status,
  output logic error_query,
  output logic complete_cmd,
  output logic enable_write,
  output logic [7:0] enable_wdata
);
  initial begin
    clear_status = 1'b0;
    error_query = 1'b0;
    complete_cmd = 1'b0;
    enable_write = 1'b0;
    enable_wdata = 8'h00;
  end

  // Op 0 clear, 1 error readout, 2 completion, 3 enable write
  task automatic send(input logic [1:0] op, input logic [7:0] d);
    @(negedge clk);
    clear_status = (op == 2'd0);
    error_query = (op == 2'd1);
    complete_cmd = (op == 2'd2);
    enable_write = (op == 2'd3);
    enable_wdata = d;
    @(negedge clk);
    {clear_status, error_query, complete_cmd, enable_write} = 4'h0;
    // Data is stale outside the strobe, so show its inverse
    enable_wdata = ~d;
  endtask : send
endmodule : ser_ctrl_model

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ser_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_status, error_query, complete_cmd, enable_write;
  logic [7:0] enable_wdata, event_status, event_status_enable, error_read_data, en, ev;
  logic terminator_seen = 1'b0;
  logic ops_busy = 1'b0;
  logic power_restored = 1'b0;
  logic link_is_gpib = 1'b1;
  logic [12:0] flt = 13'h0000;
  logic [7:0] status_byte_in = 8'h00;
  logic [7:0] srq_enable = 8'h00;
  logic event_summary_bit, master_summary, service_request, flush_output_queue, skip_to_terminator;
  logic eq_seen = 1'b0;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'h163e_49c6;
  int evb[13] = '{5, 4, 3, 2, 5, 5, 4, 4, 3, 3, 2, 2, 2};
  int erb[13] = '{-1, -1, -1, 6, 5, 4, 3, 2, 1, 0, -1, -1, -1};

  always #5 clk = ~clk;

  ser_ctrl_model u_ctrl (.clk(clk), .clear_status(clear_status), .error_query(error_query),
    .complete_cmd(complete_cmd), .enable_write(enable_write), .enable_wdata(enable_wdata));

  ser_status_event u_dut (.clk(clk), .sys_rst(sys_rst), .clear_status(clear_status),
    .error_query(error_query), .complete_cmd(complete_cmd), .enable_write(enable_write),
    .enable_wdata(enable_wdata), .terminator_seen(terminator_seen), .ops_busy(ops_busy),
    .power_restored(power_restored), .cmd_syntax_error(flt[0]), .exec_error(flt[1]),
    .device_error(flt[2]), .overlong_message(flt[3]), .header_fault(flt[4]), .format_fault(flt[5]),
    .range_fault(flt[6]), .unexecutable_cmd(flt[7]), .internal_link_fault(flt[8]),
    .backup_corrupt(flt[9]), .queue_overflow(flt[10]), .queue_data_lost(flt[11]),
    .empty_queue_read(flt[12]), .link_is_gpib(link_is_gpib), .status_byte_in(status_byte_in),
    .srq_enable(srq_enable), .event_status(event_status), .event_status_enable(event_status_enable),
    .error_read_data(error_read_data), .event_summary_bit(event_summary_bit),
    .master_summary(master_summary), .service_request(service_request),
    .flush_output_queue(flush_output_queue), .skip_to_terminator(skip_to_terminator));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic query(input logic [7:0] exp);
    exp_q.push_back(exp);
    u_ctrl.send(2'd1, 8'h00);
  endtask : query

  task automatic pulse(input int k);
    flt[k] = 1'b1;
    @(negedge clk);
    flt[k] = 1'b0;
  endtask : pulse

  // ----------------------------------------
  // Readout monitor
  // ----------------------------------------
  always @(posedge clk) eq_seen <= error_query;
  always @(negedge clk) begin
    if (eq_seen && exp_q.size() > 0) begin
      check(error_read_data, exp_q.pop_front());
    end
  end

  initial begin
    #200_000;
    num_errors++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(event_status, 8'h80);
    query(8'h00);
    check(event_status, 8'h00);
    for (int k = 0; k < 13; k++) begin
      en = 8'($random(seed));
      u_ctrl.send(2'd3, en);
      check(event_status_enable, en);
      pulse(k);
      ev = 8'h01 << evb[k];
      check(event_status, ev);
      check({7'h00, event_summary_bit}, {7'h00, |(ev & en)});
      check({7'h00, skip_to_terminator}, {7'h00, evb[k] == 5});
      check({7'h00, flush_output_queue}, {7'h00, k >= 10});
      terminator_seen = 1'b1;
      @(negedge clk);
      terminator_seen = 1'b0;
      query((erb[k] < 0) ? 8'h00 : (8'h01 << erb[k]));
      check(event_status, 8'h00);
    end
    link_is_gpib = 1'b0;
    pulse(12);
    check(event_status, 8'h00);
    check({7'h00, flush_output_queue}, 8'h00);
    srq_enable = 8'h20;
    u_ctrl.send(2'd3, 8'h10);
    pulse(1);
    check({5'h00, event_summary_bit, master_summary, service_request}, 8'h07);
    @(negedge clk);
    check({5'h00, event_summary_bit, master_summary, service_request}, 8'h06);
    pulse(6);
    u_ctrl.send(2'd0, 8'h00);
    check({event_status[7:1], master_summary}, 8'h00);
    query(8'h00);
    // Status byte bits other than 5 and 6 reach the master sum, bit 6 never does
    srq_enable = 8'h48;
    status_byte_in = 8'h40;
    @(negedge clk);
    check({6'h00, master_summary, service_request}, 8'h00);
    status_byte_in = 8'h48;
    @(negedge clk);
    check({6'h00, master_summary, service_request}, 8'h03);
    status_byte_in = 8'h00;
    srq_enable = 8'h00;
    ops_busy = 1'b1;
    u_ctrl.send(2'd2, 8'h00);
    repeat (4) @(negedge clk);
    check(event_status, 8'h00);
    ops_busy = 1'b0;
    repeat (2) @(negedge clk);
    check(event_status, 8'h01);
    power_restored = 1'b1;
    @(negedge clk);
    power_restored = 1'b0;
    check(event_status, 8'h81);
    // A fault landing with clear-status must survive it
    fork
      u_ctrl.send(2'd0, 8'h00);
      begin
        @(negedge clk);
        pulse(4);
      end
    join
    check(event_status, 8'h20);
    query(8'h20);
    check(event_status, 8'h00);
    // Second power-up in mid-run
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(event_status, 8'h80);
    check({7'h00, skip_to_terminator}, 8'h00);
    results();
  end
endmodule : tb_top
